// >>> otpbp_pkg.sv
package otpbp_pkg;
  // Register map (vendor register indices)
  localparam logic [7:0] ADDR_CLOCK_GATE = 8'h42;
  localparam logic [7:0] ADDR_ACCESS_CFG = 8'h51;
  localparam logic [7:0] ADDR_TARGET_IDX = 8'h52;
  localparam logic [7:0] ADDR_DATA_PORT = 8'h53;
  localparam logic [7:0] ADDR_CMD_CTRL = 8'h54;
  localparam logic [7:0] ADDR_CMD_RESULT = 8'h58;
  // Stored configuration window
  localparam logic [7:0] CFG_FIRST = 8'hdf;
  localparam logic [7:0] CFG_LAST = 8'he8;
  localparam int CFG_COUNT = 10;
  // Field positions
  localparam int CLK_EN_BIT = 0;
  localparam int ACC_EN_BIT = 0;
  localparam int CMD_WR_BIT = 0;
  localparam int CMD_RD_BIT = 1;
  localparam int RES_WR_OK_BIT = 0;
  // Values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Programming time
  localparam int PROG_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FETCH_CYCLES = 2;
  typedef enum logic [1:0] {OTPBP_IDLE, OTPBP_PROG, OTPBP_FETCH} otpbp_state_t;
endpackage

// >>> otpbp_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface otpbp_mem_if;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> otpbp_store.sv
`timescale 1ns/1ps
`default_nettype none
module otpbp_store #(
  parameter int DEPTH = 10
) (
  input wire logic mclk,
  input wire logic reset_n,
  otpbp_mem_if.mem port
);
  logic [7:0] cell_q [DEPTH];
  logic [7:0] rdata_q;

  // Unprogrammed cells read as zero
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cell
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          cell_q[g] <= otpbp_pkg::RESET_BYTE;
        end else if (port.we && port.addr == 4'(g)) begin
          cell_q[g] <= cell_q[g] | port.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= otpbp_pkg::RESET_BYTE;
    end else if (port.addr < 4'(DEPTH)) begin
      rdata_q <= cell_q[port.addr];
    end else begin
      rdata_q <= otpbp_pkg::RESET_BYTE;
    end
  end

  assign port.rdata = rdata_q;
endmodule // otpbp_store
`default_nettype wire

// >>> otpbp_top.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module otpbp_top #(
  parameter int PROG_CYCLES = otpbp_pkg::PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic use_stored_settings,
  input wire logic [7:0] cfg_index,
  output logic [7:0] cfg_value,
  output logic cfg_override,
  input wire logic prog_fail
);
  otpbp_mem_if mem_bus ();

  otpbp_store #(.DEPTH(otpbp_pkg::CFG_COUNT)) u_store (
    .mclk(mclk),
    .reset_n(reset_n),
    .port(mem_bus)
  );

  logic [7:0] clk_gate_q;
  logic [7:0] access_q;
  logic [7:0] index_q;
  logic [7:0] data_q;
  logic prog_bit_q;
  logic fetch_bit_q;
  logic wr_ok_q;
  logic [15:0] cnt_q;
  logic [7:0] shadow_q [otpbp_pkg::CFG_COUNT];
  otpbp_pkg::otpbp_state_t state_q;
  logic idx_ok;
  logic ready;
  logic busy;
  logic cmd_wr;
  logic [3:0] slot;

  assign idx_ok = index_q >= otpbp_pkg::CFG_FIRST && index_q <= otpbp_pkg::CFG_LAST;
  assign slot = 4'(index_q - otpbp_pkg::CFG_FIRST);
  assign ready = clk_gate_q[otpbp_pkg::CLK_EN_BIT] && access_q[otpbp_pkg::ACC_EN_BIT];
  assign busy = state_q != otpbp_pkg::OTPBP_IDLE;
  assign cmd_wr = reg_wr && reg_addr == otpbp_pkg::ADDR_CMD_CTRL && !busy;

  //////////////////////////////////////////////////////////////////////////////
  // Plain control registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_gate_q <= otpbp_pkg::RESET_BYTE;
      access_q <= otpbp_pkg::RESET_BYTE;
      index_q <= otpbp_pkg::RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == otpbp_pkg::ADDR_CLOCK_GATE) begin
        clk_gate_q <= reg_wdata;
      end
      if (reg_addr == otpbp_pkg::ADDR_ACCESS_CFG) begin
        access_q <= reg_wdata;
      end
      if (reg_addr == otpbp_pkg::ADDR_TARGET_IDX && !busy) begin
        index_q <= reg_wdata;
      end
    end
  end

  // Data port: host byte, replaced by fetched byte
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= otpbp_pkg::RESET_BYTE;
    end else if (state_q == otpbp_pkg::OTPBP_FETCH && cnt_q == 16'h0000) begin
      data_q <= idx_ok ? mem_bus.rdata : otpbp_pkg::RESET_BYTE;
    end else if (reg_wr && reg_addr == otpbp_pkg::ADDR_DATA_PORT && !busy) begin
      data_q <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= otpbp_pkg::OTPBP_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        otpbp_pkg::OTPBP_IDLE: begin
          if (cmd_wr && ready && reg_wdata[otpbp_pkg::CMD_WR_BIT]) begin
            state_q <= otpbp_pkg::OTPBP_PROG;
            cnt_q <= 16'(PROG_CYCLES - 1);
          end else if (cmd_wr && ready && reg_wdata[otpbp_pkg::CMD_RD_BIT]) begin
            state_q <= otpbp_pkg::OTPBP_FETCH;
            cnt_q <= 16'(otpbp_pkg::FETCH_CYCLES - 1);
          end
        end
        otpbp_pkg::OTPBP_PROG, otpbp_pkg::OTPBP_FETCH: begin
          if (cnt_q == 16'h0000) begin
            state_q <= otpbp_pkg::OTPBP_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= otpbp_pkg::OTPBP_IDLE;
        end
      endcase
    end
  end

  // Self-clearing command bits track the busy state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prog_bit_q <= 1'b0;
      fetch_bit_q <= 1'b0;
    end else begin
      prog_bit_q <= (state_q == otpbp_pkg::OTPBP_PROG && cnt_q != 16'h0000)
        || (cmd_wr && ready && reg_wdata[otpbp_pkg::CMD_WR_BIT]);
      fetch_bit_q <= (state_q == otpbp_pkg::OTPBP_FETCH && cnt_q != 16'h0000)
        || (cmd_wr && ready && !reg_wdata[otpbp_pkg::CMD_WR_BIT]
            && reg_wdata[otpbp_pkg::CMD_RD_BIT]);
    end
  end

  // Success flag updated only at program completion
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ok_q <= 1'b0;
    end else if (state_q == otpbp_pkg::OTPBP_PROG && cnt_q == 16'h0000) begin
      wr_ok_q <= idx_ok && !prog_fail;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory port
  assign mem_bus.we = state_q == otpbp_pkg::OTPBP_PROG && cnt_q == 16'h0000
    && idx_ok && !prog_fail;
  assign mem_bus.addr = busy ? slot : cfg_index[3:0] - otpbp_pkg::CFG_FIRST[3:0];
  assign mem_bus.wdata = data_q;

  // Shadow of stored bytes drives the cfg_value output
  genvar g;
  generate
    for (g = 0; g < otpbp_pkg::CFG_COUNT; g++) begin : g_shadow
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          shadow_q[g] <= otpbp_pkg::RESET_BYTE;
        end else if (mem_bus.we && slot == 4'(g)) begin
          shadow_q[g] <= shadow_q[g] | data_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_value <= otpbp_pkg::RESET_BYTE;
      cfg_override <= 1'b0;
    end else begin
      cfg_override <= use_stored_settings;
      if (use_stored_settings && cfg_index >= otpbp_pkg::CFG_FIRST
          && cfg_index <= otpbp_pkg::CFG_LAST) begin
        cfg_value <= shadow_q[4'(cfg_index - otpbp_pkg::CFG_FIRST)];
      end else begin
        cfg_value <= otpbp_pkg::RESET_BYTE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register readback
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= otpbp_pkg::RESET_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        otpbp_pkg::ADDR_CLOCK_GATE: reg_rdata <= clk_gate_q;
        otpbp_pkg::ADDR_ACCESS_CFG: reg_rdata <= access_q;
        otpbp_pkg::ADDR_TARGET_IDX: reg_rdata <= index_q;
        otpbp_pkg::ADDR_DATA_PORT: reg_rdata <= data_q;
        otpbp_pkg::ADDR_CMD_CTRL: reg_rdata <= {6'h00, fetch_bit_q, prog_bit_q};
        otpbp_pkg::ADDR_CMD_RESULT: reg_rdata <= {7'h00, wr_ok_q};
        default: reg_rdata <= otpbp_pkg::RESET_BYTE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_prog_self_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(prog_bit_q) |-> prog_bit_q [*8]) else $error("Program bit cleared early");
  a_prog_done: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(prog_bit_q) |-> ##1 state_q == otpbp_pkg::OTPBP_IDLE)
    else $error("Program bit cleared while busy");
  a_fetch_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(fetch_bit_q) |-> ##[1:4] !fetch_bit_q) else $error("Fetch bit stuck");
  a_ok_stable: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q != otpbp_pkg::OTPBP_PROG |=> $stable(wr_ok_q))
    else $error("Success flag moved without program");
  a_busy_ignore: assert property (@(posedge mclk) disable iff (!reset_n)
    busy && reg_wr && reg_addr == otpbp_pkg::ADDR_TARGET_IDX |=> $stable(index_q))
    else $error("Index changed while busy");
  a_write_window: assert property (@(posedge mclk) disable iff (!reset_n)
    mem_bus.we |-> idx_ok) else $error("Write outside stored window");
  a_zero_default: assert property (@(posedge mclk) disable iff (!reset_n)
    !use_stored_settings |=> cfg_value == 8'h00) else $error("Override without enable");
  a_result_read: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == otpbp_pkg::ADDR_CMD_RESULT |=> reg_rdata[0] == $past(wr_ok_q))
    else $error("Result readback mismatch");
endmodule // otpbp_top
`default_nettype wire

// >>> otpbp_host.sv
`timescale 1ns/1ps
`default_nettype none
module otpbp_host (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Vendor register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Vendor register read, data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  // Clock gate first, then access enable
  task automatic arm();
    wr(8'h42, 8'h01);
    wr(8'h51, 8'h01);
  endtask
  // Index first, then data byte
  task automatic load(input logic [7:0] idx, input logic [7:0] val);
    wr(8'h52, idx);
    wr(8'h53, val);
  endtask
endmodule // otpbp_host
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic use_stored_settings = 1'b0;
  logic prog_fail = 1'b0;
  logic [7:0] cfg_index = 8'h00;
  logic [7:0] v;
  wire logic reg_wr, reg_rd, cfg_override;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg_value;
  int miscompares = 0;
  int checks = 0;
  always #25 mclk = ~mclk;
  otpbp_host i_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  otpbp_top #(.PROG_CYCLES(8)) i_dut (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .use_stored_settings(use_stored_settings), .cfg_index(cfg_index), .cfg_value(cfg_value),
    .cfg_override(cfg_override), .prog_fail(prog_fail));
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask
  // Poll command bits until clear, bounded
  task automatic poll(input logic [7:0] mask);
    for (int n = 0; n < 50; n++) begin
      i_host.rd(8'h54, v);
      if ((v & mask) === 8'h00) return;
    end
    miscompares++;
    $display("[ERR] command bit expected 00 seen %h", v);
    test_done();
  endtask
  task automatic pin_chk(input logic [7:0] idx, input logic [7:0] exp);
    cfg_index = idx;
    repeat (3) @(negedge mclk);
    chk("cfg_value", cfg_value, exp);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(8'h42, 8'h00);
    rchk(8'h51, 8'h00);
    rchk(8'h52, 8'h00);
    rchk(8'h53, 8'h00);
    rchk(8'h54, 8'h00);
    rchk(8'h58, 8'h00);
    rchk(8'h60, 8'h00);
    chk("cfg_override", {7'h00, cfg_override}, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_program();
    i_host.arm();
    i_host.load(8'hdf, 8'h5a);
    i_host.wr(8'h54, 8'h01);
    rchk(8'h54, 8'h01);
    i_host.wr(8'h53, 8'ha5);
    poll(8'h01);
    rchk(8'h58, 8'h01);
    i_host.arm();
    i_host.wr(8'h52, 8'hdf);
    i_host.wr(8'h54, 8'h02);
    rchk(8'h54, 8'h02);
    poll(8'h02);
    rchk(8'h53, 8'h5a);
    rchk(8'h58, 8'h01);
    $display("t_program done");
  endtask
  task automatic t_retry();
    prog_fail = 1'b1;
    i_host.arm();
    i_host.load(8'he1, 8'h3c);
    i_host.wr(8'h54, 8'h01);
    poll(8'h01);
    rchk(8'h58, 8'h00);
    prog_fail = 1'b0;
    i_host.wr(8'h53, 8'h3c);
    i_host.wr(8'h54, 8'h01);
    poll(8'h01);
    rchk(8'h58, 8'h01);
    $display("t_retry done");
  endtask
  task automatic t_range();
    i_host.arm();
    i_host.load(8'he9, 8'h11);
    i_host.wr(8'h54, 8'h01);
    poll(8'h01);
    rchk(8'h58, 8'h00);
    rchk(8'h52, 8'he9);
    i_host.wr(8'h42, 8'h00);
    i_host.wr(8'h52, 8'hdf);
    i_host.wr(8'h54, 8'h02);
    rchk(8'h54, 8'h00);
    rchk(8'h42, 8'h00);
    $display("t_range done");
  endtask
  task automatic t_override();
    use_stored_settings = 1'b1;
    pin_chk(8'hdf, 8'h5a);
    chk("cfg_override", {7'h00, cfg_override}, 8'h01);
    pin_chk(8'he0, 8'h00);
    pin_chk(8'he1, 8'h3c);
    pin_chk(8'he9, 8'h00);
    use_stored_settings = 1'b0;
    pin_chk(8'hdf, 8'h00);
    $display("t_override done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    t_reset();
    t_program();
    t_retry();
    t_range();
    t_override();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
